// [logic/tbr_pkg.sv]
// Package: register map, fields, reset values and constants of the bitslip / round-trip block
package tbr_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_RTD_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_RTD_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_BITSLIP     = 8'h08;
   localparam logic [7:0] ADDR_LINK_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h10;
   localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_CLEAR   = 8'h18;
   localparam logic [7:0] ADDR_MODE        = 8'h1C;
   // Field positions
   localparam int RTD_USR_LSB      = 0;
   localparam int RTD_MEAS_LSB     = 16;
   localparam int RTD_EN_BIT       = 31;
   localparam int RX_SLIP_LSB      = 0;
   localparam int TX_SLIP_LSB      = 8;
   localparam int MAN_SLIP_LSB     = 16;
   localparam int OVR_EN_BIT       = 24;
   localparam int MODE_SLAVE_BIT   = 0;
   localparam int MODE_OP_LSB      = 1;
   // Reset values
   localparam logic [15:0] RTD_USR_RST  = 16'h0000;
   localparam logic        OVR_EN_RST   = 1'b0;
   localparam logic [7:0]  MAN_SLIP_RST = 8'h00;
   localparam logic        SLAVE_RST    = 1'b1;
   localparam logic [1:0]  OP_RST       = 2'h0;
   // Operation modes
   localparam logic [1:0] OP_DUPLEX = 2'h0;
   localparam logic [1:0] OP_RX     = 2'h1;
   localparam logic [1:0] OP_TX     = 2'h2;
   // Interrupt bits
   localparam int IRQ_LOS     = 0;
   localparam int IRQ_TXDONE  = 1;
   localparam int IRQ_RXDONE  = 2;
   localparam int IRQ_LIMIT   = 3;
   localparam int IRQ_W       = 4;
   // Status of the calibration
   typedef enum logic [1:0] {TBR_CAL_IDLE, TBR_CAL_OK, TBR_CAL_LIMIT} tbr_cal_t;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } tbr_apb_req_t;
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } tbr_apb_rsp_t;
endpackage : tbr_pkg

// [logic/tbr_sync.sv]
// Three-stage synchroniser; output changes when the second and third stages agree
`timescale 1ns/1ps
module tbr_sync
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // Data
   input  wire logic asyncIn,
   output logic      syncOut
);
   logic s1, s2, s3;
   logic next_syncOut;

   always_comb
   begin
      next_syncOut = (s2 == s3) ? s3 : syncOut;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s1      <= 1'b0;
         s2      <= 1'b0;
         s3      <= 1'b0;
         syncOut <= 1'b0;
      end
      else
      begin
         s1      <= asyncIn;
         s2      <= s1;
         s3      <= s2;
         syncOut <= next_syncOut;
      end
   end
endmodule : tbr_sync

// [logic/tbr_top.sv]
// Top: Tx bitslip compensation, round-trip pipeline pointer control, link status and APB registers
// Operation
// - When the measured round-trip delay is below the target, the read pointer steps to lengthen the pipeline by one cycle.
// - In slave mode a transmit bitslip is applied that offsets the receive word-aligner slip.
// - The receive slip amount is readable in the bitslip register.
// - The current transmit slip in bits is readable in the bitslip register.
// - With the override enable at its reset value zero the transmit slip follows the measured receive slip in slave mode and is zero in master mode.
// - In master mode the receive slip field reads zero.
// - With override enable set the software slip value sets the transmit slip instead, capped at what the receive slip leaves of the word.
// - While both reset-done flags are high, the combined transmit and receive slip stays below one core clock period, i.e. under the word width in bits.
// - The asynchronous loss-of-signal input forces the link into its loss-of-signal state; tie low if unused.
// - Transmit reset-done rises on the core clock once transmitter and transmit path are out of reset.
// - Receive reset-done rises on the core clock once receiver and receive path are out of reset.
// - Transmit analog-reset acknowledge rises when analog reset completes and falls after the request drops.
// - Receive analog-reset acknowledge rises when analog reset completes and falls after the request drops.
// - The recovered clock is forwarded only in slave mode with duplex or receive-only operation.
// - The pipeline starts at half its stage count plus one and moves at most half minus two up and half minus one down.
`timescale 1ns/1ps
module tbr_top
#(
   parameter int PIPE_B = 4,
   parameter int WORD_W = 20
)
(
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   // APB
   input  wire tbr_pkg::tbr_apb_req_t apbReq,
   output tbr_pkg::tbr_apb_rsp_t      apbRsp,
   // Transceiver status
   input  wire logic [7:0]            rxSlipMeas,
   input  wire logic [15:0]           rtdMeas,
   input  wire logic                  rtdMeasValid,
   input  wire logic                  linkLos,
   input  wire logic                  txPcsReady,
   input  wire logic                  rxPcsReady,
   input  wire logic                  txAnalogResetReq,
   input  wire logic                  rxAnalogResetReq,
   input  wire logic                  txAnalogDone,
   input  wire logic                  rxAnalogDone,
   input  wire logic                  recoveredClkIn,
   // Outputs to link side
   output logic [7:0]                 txSlip,
   output logic [PIPE_B-1:0]          pipeRdPtr,
   output logic                       losState,
   output logic                       txResetDone,
   output logic                       rxResetDone,
   output logic                       txAnalogResetAck,
   output logic                       rxAnalogResetAck,
   output logic                       recoveredClkOut,
   output logic                       irq
);
   import tbr_pkg::*;

   localparam int N = 1 << PIPE_B;
   localparam logic [PIPE_B-1:0] PTR_INIT = PIPE_B'((N / 2) + 1);
   localparam logic [PIPE_B-1:0] PTR_MIN  = PIPE_B'(2);
   localparam logic [PIPE_B-1:0] PTR_MAX  = PIPE_B'(N - 1);
   localparam logic [7:0] SLIP_MAX = 8'(WORD_W - 1);

   logic losSync, txRdySync, rxRdySync, txAreqSync, rxAreqSync, txAdnSync, rxAdnSync, measVSync;
   tbr_sync uLos  (.core_clk(core_clk), .rst(rst), .asyncIn(linkLos),          .syncOut(losSync));
   tbr_sync uTxR  (.core_clk(core_clk), .rst(rst), .asyncIn(txPcsReady),       .syncOut(txRdySync));
   tbr_sync uRxR  (.core_clk(core_clk), .rst(rst), .asyncIn(rxPcsReady),       .syncOut(rxRdySync));
   tbr_sync uTxQ  (.core_clk(core_clk), .rst(rst), .asyncIn(txAnalogResetReq), .syncOut(txAreqSync));
   tbr_sync uRxQ  (.core_clk(core_clk), .rst(rst), .asyncIn(rxAnalogResetReq), .syncOut(rxAreqSync));
   tbr_sync uTxD  (.core_clk(core_clk), .rst(rst), .asyncIn(txAnalogDone),     .syncOut(txAdnSync));
   tbr_sync uRxD  (.core_clk(core_clk), .rst(rst), .asyncIn(rxAnalogDone),     .syncOut(rxAdnSync));
   tbr_sync uMeas (.core_clk(core_clk), .rst(rst), .asyncIn(rtdMeasValid),     .syncOut(measVSync));

   // Slip word is quasi-static once aligned, so per-bit synchronisers suffice
   logic [7:0] rxSlipSync;
   for (genvar b = 0; b < 8; b++)
   begin : gSlipSync
      tbr_sync uSlip (.core_clk(core_clk), .rst(rst), .asyncIn(rxSlipMeas[b]), .syncOut(rxSlipSync[b]));
   end

   // Software state
   logic [15:0]       rtdUsr, next_rtdUsr;
   logic              rtdEn, next_rtdEn;
   logic              ovrEn, next_ovrEn;
   logic [7:0]        manSlip, next_manSlip;
   logic              slaveMode, next_slaveMode;
   logic [1:0]        opMode, next_opMode;
   logic [IRQ_W-1:0]  irqStat, next_irqStat;
   logic [IRQ_W-1:0]  irqEn, next_irqEn;
   // Block state
   logic [7:0]        rxSlipView, next_rxSlipView;
   logic [7:0]        next_txSlip;
   logic [PIPE_B-1:0] next_pipeRdPtr;
   logic              measPrev, next_measPrev;
   tbr_cal_t          calState, next_calState;
   logic              next_losState, next_txResetDone, next_rxResetDone;
   logic              next_txAck, next_rxAck, next_recEn, recEn, next_irq;
   logic              txDonePrev, rxDonePrev, losPrev;
   tbr_apb_rsp_t      next_apbRsp;
   logic [31:0]       rdData;

   function automatic logic [7:0] clampSlip(input logic [7:0] v);
      clampSlip = (v > SLIP_MAX) ? SLIP_MAX : v;
   endfunction : clampSlip

   // Override keeps the word budget: never more slip than the rx view leaves
   function automatic logic [7:0] fitSlip(input logic [7:0] v, input logic [7:0] room);
      fitSlip = (v > room) ? room : v;
   endfunction : fitSlip

   wire logic wrStb = apbReq.psel && apbReq.penable && apbReq.pwrite;
   wire logic rdStb = apbReq.psel && apbReq.penable && !apbReq.pwrite;
   wire logic measEdge = measVSync && !measPrev;
   wire logic [IRQ_W-1:0] events = {calState == TBR_CAL_LIMIT && next_calState != TBR_CAL_LIMIT ? 1'b0 :
                                    (next_calState == TBR_CAL_LIMIT && calState != TBR_CAL_LIMIT),
                                    rxResetDone && !rxDonePrev, txResetDone && !txDonePrev, losState && !losPrev};

   always_comb
   begin
      rdData = 32'h0000_0000;
      case (apbReq.paddr)
         ADDR_RTD_CTRL:    rdData = {rtdEn, 15'h0000, rtdUsr};
         ADDR_RTD_STATUS:  rdData = {14'h0000, 2'(calState), 16'h0000} | 32'(pipeRdPtr) << 24 | 32'(rtdMeas);
         ADDR_BITSLIP:     rdData = {7'h00, ovrEn, manSlip, txSlip, rxSlipView};
         ADDR_LINK_STATUS: rdData = {25'h0000000, recEn, rxAnalogResetAck, txAnalogResetAck,
                                     rxResetDone, txResetDone, losState, 1'b0};
         ADDR_IRQ_STATUS:  rdData = 32'(irqStat);
         ADDR_IRQ_ENABLE:  rdData = 32'(irqEn);
         ADDR_MODE:        rdData = {29'h00000000, opMode, slaveMode};
         default:          rdData = 32'h0000_0000;
      endcase
   end

   always_comb
   begin
      next_rtdUsr    = rtdUsr;
      next_rtdEn     = rtdEn;
      next_ovrEn     = ovrEn;
      next_manSlip   = manSlip;
      next_slaveMode = slaveMode;
      next_opMode    = opMode;
      next_irqEn     = irqEn;
      if (wrStb)
      begin
         case (apbReq.paddr)
            ADDR_RTD_CTRL:
            begin
               next_rtdUsr = apbReq.pwdata[RTD_USR_LSB +: 16];
               next_rtdEn  = apbReq.pwdata[RTD_EN_BIT];
            end
            ADDR_BITSLIP:
            begin
               next_manSlip = apbReq.pwdata[MAN_SLIP_LSB +: 8];
               next_ovrEn   = apbReq.pwdata[OVR_EN_BIT];
            end
            ADDR_IRQ_ENABLE: next_irqEn = apbReq.pwdata[IRQ_W-1:0];
            ADDR_MODE:
            begin
               next_slaveMode = apbReq.pwdata[MODE_SLAVE_BIT];
               next_opMode    = apbReq.pwdata[MODE_OP_LSB +: 2];
            end
            default: next_irqEn = irqEn;
         endcase
      end
      // Set wins over clear so an event in the clear cycle survives
      next_irqStat = irqStat;
      if (wrStb && apbReq.paddr == ADDR_IRQ_CLEAR)
         next_irqStat = irqStat & ~apbReq.pwdata[IRQ_W-1:0];
      next_irqStat = next_irqStat | events;
      next_irq = |(next_irqStat & next_irqEn);
      next_apbRsp.pready  = apbReq.psel && !apbReq.penable;
      next_apbRsp.pslverr = 1'b0;
      next_apbRsp.prdata  = apbRsp.prdata;
      if (apbReq.psel && !apbReq.penable && !apbReq.pwrite)
         next_apbRsp.prdata = rdData;
      if (rdStb)
         next_apbRsp.prdata = apbRsp.prdata;
   end

   always_comb
   begin
      next_losState    = losSync;
      next_txResetDone = txRdySync && !txAreqSync && !losSync;
      next_rxResetDone = rxRdySync && !rxAreqSync && !losSync;
      next_txAck       = txAreqSync ? (txAdnSync | txAnalogResetAck) : 1'b0;
      next_rxAck       = rxAreqSync ? (rxAdnSync | rxAnalogResetAck) : 1'b0;
      next_recEn       = slaveMode && (opMode == OP_DUPLEX || opMode == OP_RX);
      // Master mode never slips Rx, so the view is forced to zero
      next_rxSlipView  = slaveMode ? clampSlip(rxSlipSync) : 8'h00;
      next_txSlip      = txSlip;
      if (rxResetDone && txResetDone)
      begin
         if (ovrEn)
            next_txSlip = fitSlip(manSlip, SLIP_MAX - next_rxSlipView);
         else if (slaveMode)
            next_txSlip = clampSlip(SLIP_MAX - next_rxSlipView);
         else
            next_txSlip = 8'h00;
      end
      next_measPrev  = measVSync;
      next_pipeRdPtr = pipeRdPtr;
      next_calState  = rtdEn ? calState : TBR_CAL_IDLE;
      if (!rtdEn)
         next_pipeRdPtr = PTR_INIT;
      else if (measEdge)
      begin
         next_calState = TBR_CAL_OK;
         if (rtdMeas < rtdUsr)
         begin
            if (pipeRdPtr < PTR_MAX)
               next_pipeRdPtr = pipeRdPtr + PIPE_B'(1);
            else
               next_calState = TBR_CAL_LIMIT;
         end
         else if (rtdMeas > rtdUsr)
         begin
            if (pipeRdPtr > PTR_MIN)
               next_pipeRdPtr = pipeRdPtr - PIPE_B'(1);
            else
               next_calState = TBR_CAL_LIMIT;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rtdUsr <= RTD_USR_RST;
         rtdEn <= 1'b0;
         ovrEn <= OVR_EN_RST;
         manSlip <= MAN_SLIP_RST;
         slaveMode <= SLAVE_RST;
         opMode <= OP_RST;
         irqStat <= '0;
         irqEn <= '0;
         irq <= 1'b0;
         apbRsp <= '0;
         rxSlipView <= 8'h00;
         txSlip <= 8'h00;
         pipeRdPtr <= PTR_INIT;
         measPrev <= 1'b0;
         calState <= TBR_CAL_IDLE;
         losState <= 1'b0;
         losPrev <= 1'b0;
         txResetDone <= 1'b0;
         rxResetDone <= 1'b0;
         txDonePrev <= 1'b0;
         rxDonePrev <= 1'b0;
         txAnalogResetAck <= 1'b0;
         rxAnalogResetAck <= 1'b0;
         recEn <= 1'b0;
      end
      else
      begin
         rtdUsr <= next_rtdUsr;
         rtdEn <= next_rtdEn;
         ovrEn <= next_ovrEn;
         manSlip <= next_manSlip;
         slaveMode <= next_slaveMode;
         opMode <= next_opMode;
         irqStat <= next_irqStat;
         irqEn <= next_irqEn;
         irq <= next_irq;
         apbRsp <= next_apbRsp;
         rxSlipView <= next_rxSlipView;
         txSlip <= next_txSlip;
         pipeRdPtr <= next_pipeRdPtr;
         measPrev <= next_measPrev;
         calState <= next_calState;
         losState <= next_losState;
         losPrev <= losState;
         txResetDone <= next_txResetDone;
         rxResetDone <= next_rxResetDone;
         txDonePrev <= txResetDone;
         rxDonePrev <= rxResetDone;
         txAnalogResetAck <= next_txAck;
         rxAnalogResetAck <= next_rxAck;
         recEn <= next_recEn;
      end
   end

   // Clock forwarding is a registered sample; a real part would use a clock gate cell
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         recoveredClkOut <= 1'b0;
      else
         recoveredClkOut <= recEn & recoveredClkIn;
   end

   AST_PTR_STEP_UP: assert property (@(posedge core_clk) disable iff (rst)
      rtdEn && measEdge && rtdMeas < rtdUsr && pipeRdPtr < PTR_MAX |=> pipeRdPtr == $past(pipeRdPtr) + PIPE_B'(1))
      else $error("pointer did not step up");
   AST_PTR_RANGE: assert property (@(posedge core_clk) disable iff (rst)
      pipeRdPtr >= PTR_MIN || !rtdEn) else $error("pointer out of range");
   AST_MASTER_RX_ZERO: assert property (@(posedge core_clk) disable iff (rst)
      !slaveMode |=> rxSlipView == 8'h00) else $error("rx slip not zero in master mode");
   AST_OVERRIDE: assert property (@(posedge core_clk) disable iff (rst)
      ovrEn && rxResetDone && txResetDone |=> txSlip <= $past(manSlip) &&
      (txSlip == $past(manSlip) || 9'(txSlip) + 9'(rxSlipView) == 9'(SLIP_MAX)))
      else $error("override slip not applied");
   AST_AUTO_SLIP: assert property (@(posedge core_clk) disable iff (rst)
      !ovrEn && slaveMode && rxResetDone && txResetDone |=> 9'(txSlip) + 9'(rxSlipView) == 9'(SLIP_MAX))
      else $error("auto slip wrong");
   AST_SLIP_SUM: assert property (@(posedge core_clk) disable iff (rst)
      rxResetDone && txResetDone |=> 9'(txSlip) + 9'(rxSlipView) <= 9'(SLIP_MAX))
      else $error("slip exceeds word");
   AST_HOLD_IN_RESET: assert property (@(posedge core_clk) disable iff (rst)
      !rxResetDone |=> $stable(txSlip)) else $error("slip moved during reset");
   AST_LOS_DROPS_DONE: assert property (@(posedge core_clk) disable iff (rst)
      losSync |=> !rxResetDone && !txResetDone) else $error("done high during LOS");
   AST_TX_ACK_FALL: assert property (@(posedge core_clk) disable iff (rst)
      !txAreqSync |=> !txAnalogResetAck) else $error("tx ack not released");
   AST_RX_ACK_FALL: assert property (@(posedge core_clk) disable iff (rst)
      !rxAreqSync |=> !rxAnalogResetAck) else $error("rx ack not released");
endmodule : tbr_top

// [test/tb_tbr_top.sv]
// Testbench of the bitslip and round-trip block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin numErrors++; $display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
module tb_tbr_top;
   import tbr_pkg::*;
   localparam int WW = 20;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   tbr_apb_req_t req = '0;
   tbr_apb_rsp_t rsp;
   logic txReq = 1'b1;
   logic rxReq = 1'b1;
   logic rtdGo = 1'b0;
   logic linkLos = 1'b0;
   logic [7:0] slipIn = 8'h03;
   logic [15:0] rtdIn = 16'h0000;
   logic txAd, rxAd, txPr, rxPr, mValid, recClk;
   logic [7:0] slipMeas, txSlip;
   logic [15:0] rtdMeas;
   logic [3:0] ptr;
   logic losState, txDone, rxDone, txAck, rxAck, recOut, irq;
   logic [31:0] q;
   logic [15:0] seed = 16'h618B;
   logic [7:0] rx;
   logic rc;
   logic [7:0] manVals [3] = '{8'h05, 8'h13, 8'hC8};
   int checked = 0;
   int numErrors = 0;
   int n;
   always #4 core_clk = ~core_clk;
   tbr_xcvr_model xcvr (.core_clk(core_clk), .rst(rst), .txReq(txReq), .rxReq(rxReq), .rtdGo(rtdGo),
      .slipIn(slipIn), .rtdIn(rtdIn), .txAnalogDone(txAd), .rxAnalogDone(rxAd), .txPcsReady(txPr),
      .rxPcsReady(rxPr), .rtdMeasValid(mValid), .recoveredClk(recClk), .rxSlipMeas(slipMeas), .rtdMeas(rtdMeas));
   tbr_top #(.PIPE_B(4), .WORD_W(WW)) dut (.core_clk(core_clk), .rst(rst), .apbReq(req), .apbRsp(rsp),
      .rxSlipMeas(slipMeas), .rtdMeas(rtdMeas), .rtdMeasValid(mValid), .linkLos(linkLos), .txPcsReady(txPr),
      .rxPcsReady(rxPr), .txAnalogResetReq(txReq), .rxAnalogResetReq(rxReq), .txAnalogDone(txAd),
      .rxAnalogDone(rxAd), .recoveredClkIn(recClk), .txSlip(txSlip), .pipeRdPtr(ptr), .losState(losState),
      .txResetDone(txDone), .rxResetDone(rxDone), .txAnalogResetAck(txAck), .rxAnalogResetAck(rxAck),
      .recoveredClkOut(recOut), .irq(irq));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [7:0] expSlip(input logic ovr, input logic [7:0] man, input logic slv,
      input logic [7:0] r);
      logic [7:0] room;
      room = slv ? 8'(WW - 1) - r : 8'(WW - 1);
      if (ovr)
         return (man > room) ? room : man;
      return slv ? room : 8'h00;
   endfunction : expSlip
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= w;
      req.paddr <= a;
      req.pwdata <= d;
      @(posedge core_clk);
      req.penable <= 1'b1;
      do
      begin
         @(posedge core_clk);
         k++;
      end
      while (rsp.pready !== 1'b1 && k < 50);
      if (rsp.pready !== 1'b1)
         numErrors++;
      r = rsp.prdata;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb
   task automatic settle();
      repeat (14) @(posedge core_clk);
   endtask : settle
   task automatic measure(input logic [15:0] v);
      rtdIn <= v;
      rtdGo <= 1'b1;
      @(posedge core_clk);
      rtdGo <= 1'b0;
      repeat (20) @(posedge core_clk);
   endtask : measure
   task automatic giveVerdict();
      $display("comparisons %0d mismatches %0d", checked, numErrors);
      if (numErrors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : giveVerdict
   initial
   begin
      #50000;
      numErrors++;
      giveVerdict();
   end
   initial
   begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      `CHK("pipeRdPtr", 4'h9, ptr)
      `CHK("txResetDone", 1'b0, txDone)
      apb(1'b0, ADDR_BITSLIP, 32'h0, q);
      `CHK("override", OVR_EN_RST, q[OVR_EN_BIT])
      for (n = 0; n < 100 && rxAck !== 1'b1; n++) @(posedge core_clk);
      `CHK("txAck", 1'b1, txAck)
      `CHK("rxAck", 1'b1, rxAck)
      txReq <= 1'b0;
      rxReq <= 1'b0;
      settle();
      `CHK("txAck low", 1'b0, txAck)
      `CHK("rxAck low", 1'b0, rxAck)
      for (n = 0; n < 100 && rxDone !== 1'b1; n++) @(posedge core_clk);
      settle();
      `CHK("txResetDone", 1'b1, txDone)
      `CHK("rxResetDone", 1'b1, rxDone)
      $display("test reset done");
      for (int i = 0; i < 5; i++)
      begin
         seed = lfsr(seed);
         rx = (i == 0) ? 8'h00 : (i == 1) ? 8'(WW - 1) : 8'(seed % 16'(WW));
         slipIn <= rx;
         settle();
         `CHK("txSlip", expSlip(1'b0, 8'h00, 1'b1, rx), txSlip)
         apb(1'b0, ADDR_BITSLIP, 32'h0, q);
         `CHK("rx field", rx, q[7:0])
         `CHK("tx field", expSlip(1'b0, 8'h00, 1'b1, rx), q[15:8])
      end
      $display("test auto slip done");
      foreach (manVals[j])
      begin
         apb(1'b1, ADDR_BITSLIP, {7'h00, 1'b1, manVals[j], 16'h0000}, q);
         settle();
         `CHK("manual txSlip", expSlip(1'b1, manVals[j], 1'b1, rx), txSlip)
      end
      apb(1'b1, ADDR_BITSLIP, 32'h0, q);
      $display("test override done");
      rxReq <= 1'b1;
      settle();
      slipIn <= 8'h07;
      settle();
      `CHK("held txSlip", expSlip(1'b0, 8'h00, 1'b1, rx), txSlip)
      rxReq <= 1'b0;
      for (n = 0; n < 100 && rxDone !== 1'b1; n++) @(posedge core_clk);
      settle();
      `CHK("new txSlip", expSlip(1'b0, 8'h00, 1'b1, 8'h07), txSlip)
      $display("test slip hold done");
      for (int m = 0; m < 3; m++)
      begin
         apb(1'b1, ADDR_MODE, {29'h0, 2'(m), 1'b1}, q);
         settle();
         rc = recOut;
         @(posedge core_clk);
         `CHK("recClk toggles", logic'(m != 2), recOut ^ rc)
         apb(1'b0, ADDR_LINK_STATUS, 32'h0, q);
         `CHK("recClk enable", logic'(m != 2), q[6])
      end
      apb(1'b1, ADDR_MODE, {29'h0, OP_RX, 1'b0}, q);
      settle();
      `CHK("master recClk", 1'b0, recOut)
      `CHK("master txSlip", 8'h00, txSlip)
      apb(1'b0, ADDR_BITSLIP, 32'h0, q);
      `CHK("master rx field", 8'h00, q[7:0])
      apb(1'b0, 8'h40, 32'h0, q);
      `CHK("unmapped", 32'h0, q)
      $display("test modes done");
      apb(1'b1, ADDR_IRQ_CLEAR, 32'hF, q);
      apb(1'b1, ADDR_IRQ_ENABLE, 32'h8, q);
      apb(1'b1, ADDR_RTD_CTRL, 32'h8000_003E, q);
      measure(16'h003D);
      `CHK("ptr up", 4'hA, ptr)
      measure(16'h003F);
      `CHK("ptr down", 4'h9, ptr)
      repeat (8) measure(16'h003D);
      `CHK("ptr limit", 4'hF, ptr)
      `CHK("irq limit", 1'b1, irq)
      apb(1'b0, ADDR_RTD_STATUS, 32'h0, q);
      `CHK("cal state", 2'h2, q[17:16])
      apb(1'b1, ADDR_IRQ_CLEAR, 32'h8, q);
      @(posedge core_clk);
      `CHK("irq cleared", 1'b0, irq)
      $display("test round trip done");
      apb(1'b1, ADDR_IRQ_ENABLE, 32'h1, q);
      linkLos <= 1'b1;
      settle();
      `CHK("losState", 1'b1, losState)
      `CHK("los rxDone", 1'b0, rxDone)
      `CHK("irq los", 1'b1, irq)
      linkLos <= 1'b0;
      settle();
      apb(1'b1, ADDR_IRQ_CLEAR, 32'h1, q);
      @(posedge core_clk);
      `CHK("los cleared", 1'b0, losState)
      `CHK("irq off", 1'b0, irq)
      $display("test loss of signal done");
      giveVerdict();
   end
endmodule : tb_tbr_top

// [test/tbr_xcvr_model.sv]
// Model of the transceiver channel and the far link partner
`timescale 1ns/1ps
module tbr_xcvr_model
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Controls from the bench
   input  wire logic        txReq,
   input  wire logic        rxReq,
   input  wire logic        rtdGo,
   input  wire logic [7:0]  slipIn,
   input  wire logic [15:0] rtdIn,
   // Status toward the block
   output logic             txAnalogDone,
   output logic             rxAnalogDone,
   output logic             txPcsReady,
   output logic             rxPcsReady,
   output logic             rtdMeasValid,
   output logic             recoveredClk,
   output logic [7:0]       rxSlipMeas,
   output logic [15:0]      rtdMeas
);
   logic [2:0] txAd;
   logic [2:0] rxAd;
   logic [2:0] txPcs;
   logic [2:0] rxPcs;
   logic [3:0] vCnt;
   assign txAnalogDone = txAd[2];
   assign rxAnalogDone = rxAd[2];
   assign txPcsReady   = txPcs[2];
   assign rxPcsReady   = rxPcs[2];
   assign rtdMeasValid = (vCnt != 4'h0);
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         txAd <= 3'h0;
         rxAd <= 3'h0;
         txPcs <= 3'h0;
         rxPcs <= 3'h0;
         vCnt <= 4'h0;
         recoveredClk <= 1'b0;
         rxSlipMeas <= 8'h00;
         rtdMeas <= 16'h0000;
      end
      else
      begin
         // Analog reset finishes three cycles after the request
         txAd <= {txAd[1:0], txReq};
         rxAd <= {rxAd[1:0], rxReq};
         txPcs <= {txPcs[1:0], ~txReq & ~txAnalogDone};
         rxPcs <= {rxPcs[1:0], ~rxReq & ~rxAnalogDone};
         // Recovered clock toggles every core clock, so it runs at half the core clock rate
         recoveredClk <= ~recoveredClk;
         rxSlipMeas <= slipIn;
         // Value held only while valid; otherwise it keeps changing
         vCnt <= rtdGo ? 4'hC : (vCnt != 4'h0) ? vCnt - 4'h1 : 4'h0;
         rtdMeas <= rtdGo ? rtdIn : (vCnt != 4'h0) ? rtdMeas : ~rtdMeas;
      end
   end
endmodule : tbr_xcvr_model
